// [verilog/mamd_pkg.sv]
// address map constants, register offsets and reset values for the map decoder
package mamd_pkg;
  localparam int          CPU_ADDR_W   = 16;       // 64 Kbyte byte address space
  localparam int          DATA_W       = 8;        // byte-wide registers and memories
  localparam int          APB_ADDR_W   = 18;       // byte address is four times the index
  localparam int          RAM_BYTES    = 128;
  localparam int          FLASH_BYTES  = 1024;
  localparam int          N_RW         = 23;       // number of read/write peripheral regs
  // region bounds
  localparam logic [15:0] PERIPH_LAST  = 16'h007F;
  localparam logic [15:0] RAM_BASE     = 16'h0080;
  localparam logic [15:0] RAM_LAST     = 16'h00FF;
  localparam logic [15:0] STACK_BASE   = 16'h00C0;
  localparam logic [15:0] FLASH_BASE   = 16'hFC00;
  localparam logic [15:0] SECT0_SMALL  = 16'hFE00; // sector 0 base, small option
  localparam logic [15:0] SECT0_LARGE  = 16'hFC00; // sector 0 base, large option
  // read-only register indexes
  localparam logic [15:0] REG_LT_CAPTURE = 16'h000C;
  localparam logic [15:0] REG_CNT_HIGH   = 16'h000E;
  localparam logic [15:0] REG_CNT_LOW    = 16'h000F;
  localparam logic [15:0] REG_CONV_HIGH  = 16'h0035;
  localparam logic [7:0]  RO_RESET       = 8'h00;
  // read/write register indexes, in table order
  localparam logic [7:0] RW_OFS [N_RW] = '{
    8'h00, 8'h01, 8'h02, 8'h0B, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h18, 8'h2F,
    8'h34, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3D, 8'h3E, 8'h3F, 8'h47, 8'h48};
  localparam logic [7:0] RW_RST [N_RW] = '{
    8'h00, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h03, 8'h09, 8'h00, 8'h00};
  // table slots that the block's own logic uses
  localparam int          IDX_PORT_DATA = 0;
  localparam int          IDX_PORT_DIR  = 1;
  localparam int          IDX_TRIM      = 16;
  localparam int          IDX_INTEGRITY = 17;
  localparam int          IDX_VOLT      = 19;
  localparam int          IDX_CLKSW     = 20;
  localparam int          IDX_MUX0      = 21;
  localparam int          IDX_MUX1      = 22;
  localparam logic [7:0]  MUX_KEY0      = 8'h55;
  localparam logic [7:0]  MUX_KEY1      = 8'hAA;
  localparam logic [7:0]  FIXED_READ    = 8'h00;  // answer for holes in the map
  typedef enum logic [2:0] {
    MAMD_UNPOP  = 3'b000,
    MAMD_PERIPH = 3'b001,
    MAMD_RAM    = 3'b010,
    MAMD_STACK  = 3'b011,
    MAMD_FSECT1 = 3'b100,
    MAMD_FSECT0 = 3'b101
  } mamd_region_t;
endpackage

// [verilog/mamd_decoder.sv]
// address map decoder with peripheral register bank, ram and flash array
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module mamd_decoder
  import mamd_pkg::*;
#(
  parameter int P_RAM_BYTES   = mamd_pkg::RAM_BYTES,
  parameter int P_FLASH_BYTES = mamd_pkg::FLASH_BYTES
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_resetn,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [mamd_pkg::APB_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  input  wire logic [3:0]                  i_pstrb,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic [7:0]                  i_port_pins,
  output logic      [7:0]                  o_port_out,
  output logic      [7:0]                  o_port_oe_n,
  output logic                             o_reset_pin_is_port,
  input  wire logic                        i_sector0_large,
  input  wire logic                        i_icp_program,
  input  wire logic [7:0]                  i_capture_value,
  input  wire logic [7:0]                  i_count_high,
  input  wire logic [7:0]                  i_count_low,
  input  wire logic [7:0]                  i_conv_high,
  output mamd_pkg::mamd_region_t           o_region,
  output logic [mamd_pkg::N_RW*8-1:0]      o_rw_regs
);
  import mamd_pkg::*;

  // the map leaves exactly these sizes; other sizes would overlap regions
  // checked while the design is elaborated, so a bad size never builds
  if (P_RAM_BYTES != RAM_BYTES || P_FLASH_BYTES != FLASH_BYTES) begin : g_size_check
    $error("mamd_decoder: memory sizes must match the fixed address map");
  end

  // apb phases
  // the slave answers with zero wait states: ready is a registered copy
  // of the setup cycle, so every access phase lasts exactly one clock
  // a write with byte lane 0 strobed therefore commits at the single edge that ends the access
  logic        setup;                      // first cycle of a transfer
  logic        wr_go;                      // write commits at this edge
  logic [15:0] cpu_addr;                   // byte address seen by the core
  assign setup    = i_psel & ~i_penable;
  assign wr_go    = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];
  assign cpu_addr = i_paddr[17:2];

  // pin and strap synchronisers
  // every asynchronous level passes two flops; only the second is read
  logic [7:0]  pins_s1_q;                  // first stage, read only by second
  logic [7:0]  pins_s2_q;                  // safe pin level
  logic        opt_s1_q;                   // strap first stage
  logic        opt_s2_q;                   // strap safe level
  logic        icp_s1_q;                   // programming mode first stage
  logic        icp_s2_q;                   // programming mode safe level
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pins_s1_q <= 8'h00;
      pins_s2_q <= 8'h00;
      icp_s1_q  <= 1'b0;
      icp_s2_q  <= 1'b0;
    end else begin
      pins_s1_q <= i_port_pins;
      pins_s2_q <= pins_s1_q;
      icp_s1_q  <= i_icp_program;
      icp_s2_q  <= icp_s1_q;
    end
  end

  // strap synchroniser runs through reset so that it is already flushed
  // when the option is caught at the first edge after release
  // a reset here would make the option read as small every time
  always_ff @(posedge i_clock) begin
    opt_s1_q <= i_sector0_large;
    opt_s2_q <= opt_s1_q;
  end

  // option byte caught once after reset release, then frozen
  logic        opt_taken_q;                // strap already sampled
  logic        sect0_large_q;              // sector 0 covers whole flash
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      opt_taken_q   <= 1'b0;
      sect0_large_q <= 1'b0;
    end else if (!opt_taken_q) begin
      opt_taken_q   <= 1'b1;
      sect0_large_q <= opt_s2_q;
    end
  end

  // region decode
  // order matters: stack is tested before ram, sector 0 before sector 1,
  // so the narrower range wins where two ranges overlap
  // anything not claimed falls through to the unpopulated answer
  logic [15:0]  sect0_base;
  mamd_region_t region;
  assign sect0_base = sect0_large_q ? SECT0_LARGE : SECT0_SMALL;
  always_comb begin
    if (cpu_addr <= PERIPH_LAST) begin
      region = MAMD_PERIPH;
    end else if (cpu_addr >= STACK_BASE && cpu_addr <= RAM_LAST) begin
      region = MAMD_STACK;
    end else if (cpu_addr >= RAM_BASE && cpu_addr <= RAM_LAST) begin
      region = MAMD_RAM;
    end else if (cpu_addr >= sect0_base) begin
      region = MAMD_FSECT0;
    end else if (cpu_addr >= FLASH_BASE) begin
      region = MAMD_FSECT1;
    end else begin
      region = MAMD_UNPOP;
    end
  end

  // read/write peripheral registers, one slot per table entry
  // the slot tables keep offsets and reset values in matching order, so adding a
  // register is one entry in each table plus N_RW and never a change to this loop
  logic [7:0] rw_q [N_RW];
  logic [N_RW-1:0] rw_hit;                 // address matches a slot
  genvar g;
  generate
    for (g = 0; g < N_RW; g++) begin : g_rw
      assign rw_hit[g] = (region == MAMD_PERIPH) && (cpu_addr[7:0] == RW_OFS[g]);
      always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
          rw_q[g] <= RW_RST[g];
        end else if (wr_go && rw_hit[g]) begin
          rw_q[g] <= i_pwdata[7:0];
        end
      end
      assign o_rw_regs[g*8 +: 8] = rw_q[g];
    end
  endgenerate

  // read-only images of peripheral state; the bus never writes them
  logic [7:0] capture_q;
  logic [7:0] cnt_high_q;
  logic [7:0] cnt_low_q;
  logic [7:0] conv_high_q;
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      capture_q   <= RO_RESET;
      cnt_high_q  <= RO_RESET;
      cnt_low_q   <= RO_RESET;
      conv_high_q <= RO_RESET;
    end else begin
      capture_q   <= i_capture_value;
      cnt_high_q  <= i_count_high;
      cnt_low_q   <= i_count_low;
      conv_high_q <= i_conv_high;
    end
  end

  // ram, stack included at its top
  // no reset on the array: contents are undefined after power-up and
  // leaving the reset out keeps the storage cheap
  logic [7:0] ram_q [P_RAM_BYTES];
  always_ff @(posedge i_clock) begin
    if (wr_go && (region == MAMD_RAM || region == MAMD_STACK)) begin
      ram_q[cpu_addr[6:0]] <= i_pwdata[7:0];
    end
  end

  // flash array; sector 0 only writable in programming mode
  logic [7:0] flash_q [P_FLASH_BYTES];
  logic       flash_wr;
  assign flash_wr = wr_go && (region == MAMD_FSECT1 ||
                              (region == MAMD_FSECT0 && icp_s2_q));
  always_ff @(posedge i_clock) begin
    if (flash_wr) begin
      flash_q[cpu_addr[9:0]] <= i_pwdata[7:0];
    end
  end

  // read data select, reserved and empty holes give the fixed value
  // holes also raise the error response so that a stray access is seen
  // the read-only images are tested before the slot search on purpose
  logic [7:0] rd_byte;
  logic       rd_err;
  logic [7:0] port_view;
  assign port_view = (rw_q[IDX_PORT_DATA] & rw_q[IDX_PORT_DIR]) |
                     (pins_s2_q & ~rw_q[IDX_PORT_DIR]);
  always_comb begin
    rd_byte = FIXED_READ;
    rd_err  = 1'b0;
    if (region == MAMD_RAM || region == MAMD_STACK) begin
      rd_byte = ram_q[cpu_addr[6:0]];
    end else if (region == MAMD_FSECT0 || region == MAMD_FSECT1) begin
      rd_byte = flash_q[cpu_addr[9:0]];
    end else if (region == MAMD_UNPOP) begin
      rd_err  = 1'b1;
    end else if (rw_hit[IDX_PORT_DATA]) begin
      rd_byte = port_view;
    end else if (cpu_addr == REG_LT_CAPTURE) begin
      rd_byte = capture_q;
    end else if (cpu_addr == REG_CNT_HIGH) begin
      rd_byte = cnt_high_q;
    end else if (cpu_addr == REG_CNT_LOW) begin
      rd_byte = cnt_low_q;
    end else if (cpu_addr == REG_CONV_HIGH) begin
      rd_byte = conv_high_q;
    end else begin
      for (int k = 0; k < N_RW; k++) begin
        if (rw_hit[k]) begin
          rd_byte = rw_q[k];
        end
      end
      if (rw_hit == '0) begin
        rd_err  = 1'b1;                    // reserved hole
      end
    end
  end

  // answer registered in setup, presented in the first access cycle
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      o_region  <= MAMD_UNPOP;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_prdata  <= {24'h00_0000, i_pwrite ? FIXED_READ : rd_byte};
        o_pslverr <= rd_err;
        o_region  <= region;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // port pins and shared reset pin mux
  // pin drivers follow the register one cycle later; the shared pin stays
  // a reset input unless both key bytes hold their values at once
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_port_out          <= RW_RST[IDX_PORT_DATA];
      o_port_oe_n         <= ~RW_RST[IDX_PORT_DIR];
      o_reset_pin_is_port <= 1'b0;
    end else begin
      o_port_out          <= rw_q[IDX_PORT_DATA];
      o_port_oe_n         <= ~rw_q[IDX_PORT_DIR];
      o_reset_pin_is_port <= (rw_q[IDX_MUX0] == MUX_KEY0) &&
                             (rw_q[IDX_MUX1] == MUX_KEY1);
    end
  end

  // checks
  a_setup_answer: assert property (@(posedge i_clock) disable iff (!i_resetn)
    setup |=> o_pready ##1 !o_pready)
    else $error("answer not one access cycle after setup");
  a_stack_decode: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && cpu_addr >= 16'h00C0 && cpu_addr <= 16'h00FF) |=> o_region == MAMD_STACK)
    else $error("stack range not decoded as stack");
  a_vector_sector: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && cpu_addr >= 16'hFE00) |=> o_region == MAMD_FSECT0)
    else $error("vector area not in sector 0");
  a_hole_fixed: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && !i_pwrite && cpu_addr >= 16'h0100 && cpu_addr < 16'hFC00)
      |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unpopulated read not answered with fixed value");
  a_reserved_fixed: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && !i_pwrite && cpu_addr >= 16'h0040 && cpu_addr <= 16'h0046)
      |=> o_pslverr && o_prdata[7:0] == 8'h00)
    else $error("reserved read not answered with fixed value");
  a_capture_ro: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (wr_go && cpu_addr == 16'h000C) |=> capture_q == $past(i_capture_value))
    else $error("write reached the capture register");
  a_pin_mux_keys: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(o_reset_pin_is_port) |-> $past(rw_q[IDX_MUX0]) == 8'h55 &&
                                   $past(rw_q[IDX_MUX1]) == 8'hAA)
    else $error("shared pin released without both keys");
  a_reset_values: assert property (@(posedge i_clock)
    !i_resetn |=> rw_q[IDX_TRIM] == 8'hFF && rw_q[IDX_INTEGRITY] == 8'h00 &&
                  rw_q[IDX_VOLT] == 8'h03 && rw_q[IDX_CLKSW] == 8'h09)
    else $error("register reset value wrong");
  a_port_reset: assert property (@(posedge i_clock)
    !i_resetn |=> o_port_oe_n == 8'hF7 && !o_reset_pin_is_port)
    else $error("port direction or pin mux reset wrong");
  a_port_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && !i_pwrite && cpu_addr == 16'h0000) |=> o_prdata[7:0] == $past(port_view))
    else $error("port data read does not mix pins and latch");
  a_sect0_protect: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (wr_go && region == MAMD_FSECT0 && !icp_s2_q) |-> !flash_wr)
    else $error("sector 0 written outside programming mode");
  // error response only ever stands together with ready
  a_err_with_ready: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_pslverr |-> o_pready)
    else $error("error response without ready");
  // writes never return read data
  a_write_no_data: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && i_pwrite) |=> o_prdata == 32'h0000_0000)
    else $error("write returned read data");
  // only the low byte lane carries data
  a_upper_lanes: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_pready |-> o_prdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  // register window decodes as peripheral space
  a_periph_decode: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && cpu_addr <= 16'h007F) |=> o_region == MAMD_PERIPH)
    else $error("register window not decoded as peripheral");
  // lower half of ram is plain ram
  a_ram_decode: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && cpu_addr >= 16'h0080 && cpu_addr <= 16'h00BF) |=> o_region == MAMD_RAM)
    else $error("ram range not decoded as ram");
  // lower flash half follows the option
  a_flash_split: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (setup && cpu_addr >= 16'hFC00 && cpu_addr <= 16'hFDFF)
      |=> o_region == (sect0_large_q ? MAMD_FSECT0 : MAMD_FSECT1))
    else $error("lower flash half decoded against the option");
  // option frozen once caught
  a_strap_frozen: assert property (@(posedge i_clock) disable iff (!i_resetn)
    opt_taken_q |=> $stable(sect0_large_q))
    else $error("sector 0 option changed after reset");
  // a missing first key keeps the pin in reset mode
  a_pin_reset_mode: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (rw_q[IDX_MUX0] != MUX_KEY0) |=> !o_reset_pin_is_port)
    else $error("shared pin left reset mode without first key");
  // writes that hit no slot leave every read/write register alone
  a_hole_write_safe: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (wr_go && rw_hit == '0) |=> $stable(o_rw_regs))
    else $error("write outside the slots changed a register");
  // port driver follows the data register
  a_port_follow: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_port_out == $past(rw_q[IDX_PORT_DATA]))
    else $error("port output does not follow data register");
  // main scenarios seen
  c_sect0_write: cover property (@(posedge i_clock) disable iff (!i_resetn)
    wr_go && region == MAMD_FSECT0 && icp_s2_q);
  c_hole_read: cover property (@(posedge i_clock) disable iff (!i_resetn)
    setup && !i_pwrite && region == MAMD_UNPOP);
  c_ram_write: cover property (@(posedge i_clock) disable iff (!i_resetn)
    wr_go && region == MAMD_RAM);
  c_flash_read: cover property (@(posedge i_clock) disable iff (!i_resetn)
    setup && !i_pwrite && region == MAMD_FSECT1);
  c_pin_release: cover property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(o_reset_pin_is_port));
endmodule

// [bench/mamd_cpu_model.sv]
// cpu core model that issues byte accesses to the map decoder over apb
`timescale 1ns/1ns
module mamd_cpu_model (
  input  wire logic        i_clock,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [17:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  output logic [3:0]       o_pstrb
);
  // bus idle from time zero
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 18'h00000;
    o_pwdata  = 32'h00000000;
    o_pstrb   = 4'h0;
  end
  // one byte transfer; holes are only touched by refusal
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] wdat,
                      output logic [7:0] rdat, output logic err);
    @(posedge i_clock);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= {addr, 2'b00};
    o_pwdata  <= {24'h000000, wdat};
    o_pstrb   <= 4'hF;
    @(posedge i_clock);
    o_penable <= 1'b1;
    // wait for the answer, however slow; only the bench timeout ends it
    @(posedge i_clock);
    while (i_pready !== 1'b1) @(posedge i_clock);
    rdat = i_prdata[7:0];
    err  = i_pslverr;
    // release; stale data is scrambled so nobody relies on it
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_pwdata  <= ~o_pwdata;
  endtask
endmodule

// [bench/tb.sv]
// self-checking bench for the address map decoder
`timescale 1ns/1ns
module tb;
  import mamd_pkg::*;
  logic i_clock, i_resetn, psel, penable, pwrite, pslverr, pready, is_port;
  logic i_sector0_large, i_icp_program;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [183:0] rw_regs;
  logic [7:0]  pins, port_out, oe_n, cap, cnt_h, cnt_l, conv, rd;
  logic        er;
  mamd_region_t region;
  int fails, total_checks, cycles;
  // reset table, region table and read-only/hole address lists
  logic [15:0] ra [10] = '{16'h0000, 16'h0001, 16'h0002, 16'h000C, 16'h000E, 16'h000F,
                           16'h0036, 16'h0039, 16'h003E, 16'h003F};
  logic [7:0]  rv [10] = '{8'h00, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03, 8'h09};
  logic [15:0] ga [10] = '{16'h0010, 16'h0090, 16'h00C0, 16'h00FF, 16'h0100, 16'hFBFF,
                           16'hFC00, 16'hFDFF, 16'hFE00, 16'hFFFF};
  logic [2:0]  gv [10] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h0, 3'h0, 3'h4, 3'h4, 3'h5, 3'h5};
  logic [15:0] oa [4]  = '{16'h000C, 16'h000E, 16'h000F, 16'h0035};
  logic [7:0]  ov [4]  = '{8'h5A, 8'hC3, 8'h96, 8'hE1};
  logic [15:0] ha [4]  = '{16'h0005, 16'h0014, 16'h0040, 16'h0100};

  mamd_decoder mamd_decoder_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_port_pins(pins), .o_port_out(port_out), .o_port_oe_n(oe_n),
    .o_reset_pin_is_port(is_port), .i_sector0_large(i_sector0_large),
    .i_icp_program(i_icp_program), .i_capture_value(cap), .i_count_high(cnt_h),
    .i_count_low(cnt_l), .i_conv_high(conv), .o_region(region), .o_rw_regs(rw_regs));
  mamd_cpu_model mamd_cpu_model_inst (.i_clock(i_clock), .i_prdata(prdata),
    .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));

  // 125 MHz clock
  initial i_clock = 1'b0;
  always #4 i_clock = ~i_clock;
  // cut a hang short
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  // byte comparison, four-state exact
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    mamd_cpu_model_inst.xfer(1'b1, a, d, rd, er);
  endtask
  // read one byte and check data and error flag
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input logic exp_err);
    mamd_cpu_model_inst.xfer(1'b0, a, 8'h00, rd, er);
    chk("read data", exp, rd);
    chk("error flag", {7'h00, exp_err}, {7'h00, er});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    i_resetn = 1'b0;
    i_sector0_large = 1'b0;
    i_icp_program = 1'b0;
    pins = 8'h00;
    cap = 8'h00;
    cnt_h = 8'h00;
    cnt_l = 8'h00;
    conv = 8'h00;
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clock);
    // reset values of the bank and pin outputs
    chk("oe_n", 8'hF7, oe_n);
    chk("pin is port", 8'h00, {7'h00, is_port});
    chk("trim slot", 8'hFF, rw_regs[135:128]);
    chk("clock switch slot", 8'h09, rw_regs[167:160]);
    for (int k = 0; k < 10; k++) rdc(ra[k], rv[k], 1'b0);
    mamd_cpu_model_inst.xfer(1'b0, 16'h003A, 8'h00, rd, er);
    chk("integrity", 8'h00, rd & 8'hF7);
    // region decode across the map
    for (int k = 0; k < 10; k++) begin
      mamd_cpu_model_inst.xfer(1'b0, ga[k], 8'h00, rd, er);
      chk("region", {5'h00, gv[k]}, {5'h00, region});
    end
    // ram, stack top and flash sectors; sector 0 locked outside programming
    wr(16'h0080, 8'h12);
    wr(16'h00FF, 8'h34);
    wr(16'hFC00, 8'h56);
    i_icp_program <= 1'b1;
    repeat (4) @(posedge i_clock);
    wr(16'hFFFE, 8'h78);
    i_icp_program <= 1'b0;
    repeat (4) @(posedge i_clock);
    wr(16'hFFFE, 8'h9A);
    rdc(16'h0080, 8'h12, 1'b0);
    rdc(16'h00FF, 8'h34, 1'b0);
    rdc(16'hFC00, 8'h56, 1'b0);
    rdc(16'hFFFE, 8'h78, 1'b0);
    // writable registers keep what was written
    wr(16'h0036, 8'hA5);
    wr(16'h0010, 8'h3C);
    rdc(16'h0036, 8'hA5, 1'b0);
    rdc(16'h0010, 8'h3C, 1'b0);
    // read-only mirrors ignore writes
    cap <= ov[0];
    cnt_h <= ov[1];
    cnt_l <= ov[2];
    conv <= ov[3];
    for (int k = 0; k < 4; k++) wr(oa[k], ~ov[k]);
    for (int k = 0; k < 4; k++) rdc(oa[k], ov[k], 1'b0);
    // holes: writes refused, reads fixed with error
    for (int k = 0; k < 4; k++) begin
      wr(ha[k], 8'h77);
      chk("write error", 8'h01, {7'h00, er});
      rdc(ha[k], FIXED_READ, 1'b1);
    end
    // port data mixes latch for outputs and pins for inputs
    pins <= 8'h55;
    wr(16'h0001, 8'h0F);
    wr(16'h0000, 8'hAA);
    repeat (2) @(posedge i_clock);
    chk("port out", 8'hAA, port_out);
    chk("oe_n", 8'hF0, oe_n);
    rdc(16'h0000, 8'h5A, 1'b0);
    // shared pin needs both keys, and drops when one is undone
    wr(16'h0047, MUX_KEY0);
    repeat (2) @(posedge i_clock);
    chk("pin is port", 8'h00, {7'h00, is_port});
    wr(16'h0048, MUX_KEY1);
    repeat (2) @(posedge i_clock);
    chk("pin is port", 8'h01, {7'h00, is_port});
    wr(16'h0047, 8'h00);
    repeat (2) @(posedge i_clock);
    chk("pin is port", 8'h00, {7'h00, is_port});
    // second reset with the large sector 0 option strapped
    i_resetn <= 1'b0;
    i_sector0_large <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clock);
    chk("oe_n", 8'hF7, oe_n);
    chk("data slot", 8'h00, rw_regs[7:0]);
    mamd_cpu_model_inst.xfer(1'b0, 16'hFC00, 8'h00, rd, er);
    chk("region", 8'h05, {5'h00, region});
    chk("flash kept", 8'h56, rd);
    stop_test();
  end
endmodule
